// ### hdl/slc_map.vh
`ifndef SLC_MAP_VH
`define SLC_MAP_VH

// Register offsets
`define SLC_CTRL_OFS     8'h00
`define SLC_STAT_OFS     8'h01

// Control register fields
`define SLC_SEN_BIT      0
`define SLC_MODE_LSB     1
`define SLC_MODE_MSB     2
`define SLC_CTRL_RST     8'h00

// Sleep mode encodings
`define SLC_MODE_IDLE    2'h0
`define SLC_MODE_STBY    2'h1
`define SLC_MODE_PDOWN   2'h2
`define SLC_MODE_RSVD    2'h3

// Status register fields
`define SLC_STAT_ST_LSB  0
`define SLC_STAT_ST_MSB  2
`define SLC_STAT_DBG_BIT 3

// Wake timing, in peripheral clock cycles
`define SLC_WAKE_CYC     3'h6

// Brown-out active-mode setting that stretches wake-up
`define SLC_BOD_WAIT_CFG 2'h3

`endif

// ### hdl/slc_sync3.v
`timescale 1ns/100ps

// Three-stage synchroniser; a bit changes only once stages two and three agree
module slc_sync3 #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clock,
	input  wire             rst_n,
	// Asynchronous inputs
	input  wire [WIDTH-1:0] async_in,
	// Filtered result
	output reg  [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] stage1;
	reg [WIDTH-1:0] stage2;
	reg [WIDTH-1:0] stage3;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1   <= {WIDTH{1'b0}};
			stage2   <= {WIDTH{1'b0}};
			stage3   <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			// Disagreeing stages mean the input is still moving; hold the old value
			sync_out <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & sync_out);
		end
	end

endmodule // slc_sync3

// ### hdl/slc_sleep_controller.v
`timescale 1ns/100ps
`include "slc_map.vh"

// Function
// RULE1: One active state plus three sleep states
// RULE2: Each sleep state entered directly from active
// RULE3: Sleep halts CPU; only interrupt or reset wakes; a debugger break also wakes here
// RULE4: Interrupt wake runs handler, then resumes after sleep
// RULE5: Any reset ends sleep, restarts at vector
// RULE6: Register file, SRAM, peripheral registers are retained
// RULE7: Debugger break wakes device without pending interrupt
// RULE8: Software enables interrupts, writes mode, executes sleep
// RULE9: Idle stops only CPU clock; all interrupts wake
// RULE10: Standby wake sources, some gated by run-in-standby
// RULE11: Standby keeps clocks only with run-in-standby set; ULP 32k enable stays on here regardless
// RULE12: ADC runs in standby; window wakes if enabled
// RULE13: Power-down keeps watchdog, timer; pin and address wake
// RULE14: Power-down stops clocks except ULP/RTC when used
// RULE15: Wake takes six cycles plus oscillator start-up
// RULE16: Idle wake takes only the six cycles
// RULE17: Brown-out setting three holds wake until ready
// RULE18: Controller logic runs on the peripheral clock
// RULE19: Mode field: idle 0, standby 1, power-down 2
// RULE20: Software sets sleep enable before sleep instruction
// RULE21: Sleep instruction with enable clear is ignored
// RULE22: Reserved mode encoding keeps controller active
module slc_sleep_controller (
	// Peripheral clock and device reset
	input  wire       clock,
	input  wire       rst_n,
	// Register port
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_write,
	input  wire       reg_read,
	output reg  [7:0] reg_rdata,
	// CPU core
	input  wire       sleep_instr,
	output reg        cpu_clk_en,
	output reg        wake_irq,
	// Asynchronous wake sources and debug
	input  wire       pin_irq,
	input  wire       twi_addr_match,
	input  wire       pit_irq,
	input  wire       rtc_irq,
	input  wire       debug_break,
	// Synchronous wake sources
	input  wire       tcb_irq,
	input  wire       usart_sof_irq,
	input  wire       adc_window_irq,
	input  wire       other_irq,
	// Run-in-standby bits
	input  wire       per_run_in_standby_bit,
	input  wire       rtc_run_in_standby_bit,
	input  wire       adc_run_in_standby_bit,
	input  wire       usart_run_in_standby_bit,
	input  wire       mclk_run_in_standby_bit,
	input  wire       rtcclk_run_in_standby_bit,
	// Clock controller and brown-out detector
	input  wire       osc_ready,
	input  wire       bod_ready,
	input  wire [1:0] brownout_config_fuse,
	input  wire       bod_uses_ulp,
	input  wire       watchdog_uses_ulp,
	// Domain enables
	output reg        per_clk_en,
	output reg        adc_clk_en,
	output reg        rtc_en,
	output reg        mclk_src_en,
	output reg        rtcclk_src_en,
	output reg        ulp32k_en,
	output reg        pit_en,
	output reg        watchdog_en,
	// Sleep status
	output reg        sleeping,
	output reg        mem_retain
);

	localparam ST_ACTIVE   = 3'b000;
	localparam ST_IDLE     = 3'b001;
	localparam ST_STBY     = 3'b010;
	localparam ST_PDOWN    = 3'b011;
	localparam ST_WAKE_OSC = 3'b100;
	localparam ST_WAKE_CNT = 3'b101;
	localparam ST_WAKE_BOD = 3'b110;

	// Synchronised asynchronous inputs
	wire [6:0] async_vec;
	wire [6:0] sync_vec;
	wire       pin_s;
	wire       twi_s;
	wire       pit_s;
	wire       rtc_s;
	wire       dbg_s;
	wire       osc_ready_s;
	wire       bod_ready_s;

	// Control and state
	reg  [1:0] sleep_mode_select;
	reg        sleep_enable_bit;
	reg  [2:0] state;
	reg  [2:0] next_state;
	reg  [2:0] wake_cnt;
	reg  [2:0] next_wake_cnt;
	reg        wake_cause_irq;
	reg        next_wake_cause_irq;
	reg        last_wake_dbg;
	reg        next_last_wake_dbg;
	reg        next_wake_irq;

	// Wake decision
	reg        wake_src;
	reg        bod_wait;

	// Next values of the enables
	reg        next_cpu_clk_en;
	reg        next_per_clk_en;
	reg        next_adc_clk_en;
	reg        next_rtc_en;
	reg        next_mclk_src_en;
	reg        next_rtcclk_src_en;
	reg        next_ulp32k_en;

	assign async_vec = {bod_ready, osc_ready, debug_break, rtc_irq, pit_irq, twi_addr_match,
		pin_irq};

	slc_sync3 #(
		.WIDTH    (7)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in (async_vec),
		.sync_out (sync_vec)
	);

	assign pin_s       = sync_vec[0];
	assign twi_s       = sync_vec[1];
	assign pit_s       = sync_vec[2];
	assign rtc_s       = sync_vec[3];
	assign dbg_s       = sync_vec[4];
	assign osc_ready_s = sync_vec[5];
	assign bod_ready_s = sync_vec[6];

	// Register writes and reads
	always @(posedge clock or negedge rst_n) begin // [RULE18]
		if (!rst_n) begin
			sleep_mode_select <= `SLC_MODE_IDLE;
			sleep_enable_bit  <= 1'b0;
			reg_rdata         <= 8'h00;
		end else begin
			if (reg_write && reg_addr == `SLC_CTRL_OFS) begin // [RULE8]
				sleep_mode_select <= reg_wdata[`SLC_MODE_MSB:`SLC_MODE_LSB]; // [RULE19]
				sleep_enable_bit  <= reg_wdata[`SLC_SEN_BIT]; // [RULE20]
			end
			// Read data stand for exactly one cycle; unmapped offsets read zero
			if (reg_read && reg_addr == `SLC_CTRL_OFS) begin
				reg_rdata <= {5'h00, sleep_mode_select, sleep_enable_bit};
			end else if (reg_read && reg_addr == `SLC_STAT_OFS) begin
				reg_rdata <= {4'h0, last_wake_dbg, state};
			end else begin
				reg_rdata <= 8'h00;
			end
		end
	end

	// Which sources may wake each sleep state
	always @* begin
		wake_src = 1'b0;
		case (state)
			ST_IDLE: begin
				wake_src = pin_s | twi_s | pit_s | rtc_s | tcb_irq | usart_sof_irq
					| adc_window_irq | other_irq; // [RULE9]
			end
			ST_STBY: begin
				wake_src = pin_s | twi_s | tcb_irq | pit_s
					| (usart_sof_irq & usart_run_in_standby_bit)
					| (rtc_s & rtc_run_in_standby_bit); // [RULE10]
				wake_src = wake_src | (adc_window_irq & adc_run_in_standby_bit); // [RULE12]
			end
			ST_PDOWN: begin
				wake_src = pin_s | twi_s; // [RULE13]
			end
			default: begin
				wake_src = 1'b0;
			end
		endcase
	end

	always @* begin
		bod_wait = (brownout_config_fuse == `SLC_BOD_WAIT_CFG); // [RULE17]
	end

	// Sequencer
	always @* begin
		next_state          = state;
		next_wake_cnt       = wake_cnt;
		next_wake_cause_irq = wake_cause_irq;
		next_last_wake_dbg  = last_wake_dbg;
		next_wake_irq       = 1'b0;
		case (state)
			ST_ACTIVE: begin
				// Disabled sleep or reserved mode makes the instruction a no-op
				if (sleep_instr && sleep_enable_bit) begin // [RULE21]
					if (sleep_mode_select == `SLC_MODE_IDLE) begin // [RULE2]
						next_state = ST_IDLE;
					end else if (sleep_mode_select == `SLC_MODE_STBY) begin
						next_state = ST_STBY;
					end else if (sleep_mode_select == `SLC_MODE_PDOWN) begin
						next_state = ST_PDOWN;
					end else begin
						next_state = ST_ACTIVE; // [RULE22]
					end
				end
			end
			ST_IDLE, ST_STBY, ST_PDOWN: begin
				// Execution stays halted until a wake source or a break
				if (wake_src || dbg_s) begin // [RULE3] [RULE7]
					next_wake_cause_irq = wake_src;
					next_last_wake_dbg  = ~wake_src;
					next_wake_cnt       = 3'h0;
					if (state == ST_IDLE) begin
						next_state = ST_WAKE_CNT; // [RULE16]
					end else begin
						next_state = ST_WAKE_OSC; // [RULE15]
					end
				end
			end
			ST_WAKE_OSC: begin
				if (osc_ready_s) begin // [RULE15]
					next_state = ST_WAKE_CNT;
				end
			end
			ST_WAKE_CNT: begin
				next_wake_cnt = wake_cnt + 3'h1;
				if (wake_cnt == `SLC_WAKE_CYC - 3'h1) begin // [RULE15]
					// Brown-out wait overlaps the count and only ever extends it
					if (bod_wait && !bod_ready_s) begin // [RULE17]
						next_state = ST_WAKE_BOD;
					end else begin
						next_state    = ST_ACTIVE;
						next_wake_irq = wake_cause_irq; // [RULE4]
					end
				end
			end
			ST_WAKE_BOD: begin
				if (bod_ready_s) begin // [RULE17]
					next_state    = ST_ACTIVE;
					next_wake_irq = wake_cause_irq; // [RULE4]
				end
			end
			default: begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	// Domain enables follow the state being entered
	always @* begin
		next_cpu_clk_en    = 1'b0;
		next_per_clk_en    = 1'b1;
		next_adc_clk_en    = 1'b1;
		next_rtc_en        = 1'b1;
		next_mclk_src_en   = 1'b1;
		next_rtcclk_src_en = 1'b1;
		next_ulp32k_en     = 1'b1;
		case (next_state)
			ST_ACTIVE: begin
				next_cpu_clk_en = 1'b1; // [RULE1]
			end
			ST_IDLE: begin
				next_cpu_clk_en = 1'b0; // [RULE9]
			end
			ST_STBY: begin
				next_per_clk_en    = per_run_in_standby_bit; // [RULE11]
				next_rtc_en        = rtc_run_in_standby_bit; // [RULE11]
				next_mclk_src_en   = mclk_run_in_standby_bit; // [RULE11]
				next_rtcclk_src_en = rtcclk_run_in_standby_bit; // [RULE11]
				next_adc_clk_en    = adc_run_in_standby_bit; // [RULE12]
			end
			ST_PDOWN: begin
				next_per_clk_en    = 1'b0;
				next_adc_clk_en    = 1'b0;
				next_rtc_en        = 1'b0;
				next_mclk_src_en   = 1'b0; // [RULE14]
				next_rtcclk_src_en = bod_uses_ulp | watchdog_uses_ulp; // [RULE14]
				next_ulp32k_en     = bod_uses_ulp | watchdog_uses_ulp; // [RULE14]
			end
			default: begin
				// Wake states: everything but the CPU runs while the clock settles
				next_cpu_clk_en = 1'b0;
			end
		endcase
	end

	// State and output flops; any reset lands in active with the CPU running
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state          <= ST_ACTIVE; // [RULE5]
			wake_cnt       <= 3'h0;
			wake_cause_irq <= 1'b0;
			last_wake_dbg  <= 1'b0;
			wake_irq       <= 1'b0;
			cpu_clk_en     <= 1'b1;
			per_clk_en     <= 1'b1;
			adc_clk_en     <= 1'b1;
			rtc_en         <= 1'b1;
			mclk_src_en    <= 1'b1;
			rtcclk_src_en  <= 1'b1;
			ulp32k_en      <= 1'b1;
			pit_en         <= 1'b1;
			watchdog_en    <= 1'b1;
			sleeping       <= 1'b0;
			mem_retain     <= 1'b0;
		end else begin
			state          <= next_state;
			wake_cnt       <= next_wake_cnt;
			wake_cause_irq <= next_wake_cause_irq;
			last_wake_dbg  <= next_last_wake_dbg;
			wake_irq       <= next_wake_irq;
			cpu_clk_en     <= next_cpu_clk_en; // [RULE3]
			per_clk_en     <= next_per_clk_en;
			adc_clk_en     <= next_adc_clk_en;
			rtc_en         <= next_rtc_en;
			mclk_src_en    <= next_mclk_src_en;
			rtcclk_src_en  <= next_rtcclk_src_en;
			ulp32k_en      <= next_ulp32k_en;
			// Watchdog and periodic timer never stop in any mode
			pit_en         <= 1'b1; // [RULE13]
			watchdog_en    <= 1'b1; // [RULE13]
			sleeping       <= (next_state != ST_ACTIVE);
			// Retention holds through sleep and wake-up alike
			mem_retain     <= (next_state != ST_ACTIVE); // [RULE6]
		end
	end

endmodule // slc_sleep_controller

// ### test/slc_checker.sv
`timescale 1ns/100ps
`include "slc_map.vh"
module slc_checker (
	// Clock and reset
	input wire       clock,
	input wire       rst_n,
	// Observed ports
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_write,
	input wire       sleep_instr,
	input wire       cpu_clk_en,
	input wire       wake_irq,
	input wire       bod_ready,
	input wire [1:0] brownout_config_fuse,
	input wire       per_clk_en,
	input wire       mclk_src_en,
	input wire       pit_en,
	input wire       watchdog_en,
	input wire       sleeping,
	input wire       mem_retain
);
	// Shadow of the control field, old value seen by a same-cycle sleep
	reg  [2:0] ctrl;
	wire       go = sleep_instr && !sleeping;
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			ctrl <= 3'h0;
		else if (reg_write && reg_addr == `SLC_CTRL_OFS)
			ctrl <= reg_wdata[2:0];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	chk_sleep_entry: assert property (go && ctrl[0] && ctrl != 3'h7 |=> sleeping && !cpu_clk_en)
		else $error("sleep not entered");
	chk_enable_clear: assert property (go && !ctrl[0] |=> !sleeping)
		else $error("slept with enable clear");
	chk_reserved_mode: assert property (go && ctrl == 3'h7 |=> !sleeping)
		else $error("slept in reserved mode");
	chk_mem_retain: assert property (mem_retain == sleeping)
		else $error("retain mismatch");
	chk_wake_time: assert property ($rose(cpu_clk_en) |-> !$past(cpu_clk_en, 7))
		else $error("wake too fast");
	chk_irq_pulse: assert property (wake_irq |-> $rose(cpu_clk_en) ##1 !wake_irq)
		else $error("bad wake pulse");
	chk_bod_wait: assert property ($rose(cpu_clk_en) && brownout_config_fuse == `SLC_BOD_WAIT_CFG
		|-> $past(bod_ready, 3))
		else $error("ran before brown-out ready");
	chk_pdown_domains: assert property ($rose(sleeping) && $past(ctrl[2:1]) == `SLC_MODE_PDOWN
		|-> !per_clk_en && !mclk_src_en && pit_en && watchdog_en)
		else $error("power-down domains wrong");
endmodule // slc_checker

bind slc_sleep_controller slc_checker i_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write), .sleep_instr(sleep_instr),
	.cpu_clk_en(cpu_clk_en), .wake_irq(wake_irq), .bod_ready(bod_ready),
	.brownout_config_fuse(brownout_config_fuse), .per_clk_en(per_clk_en),
	.mclk_src_en(mclk_src_en), .pit_en(pit_en), .watchdog_en(watchdog_en),
	.sleeping(sleeping), .mem_retain(mem_retain));

// ### test/slc_partner.sv
`timescale 1ns/100ps
// Oscillator and brown-out readiness lag the source enable; brown-out is
// slower than the wake count so the stretch is exercised
module slc_partner #(
	parameter OSC_DLY = 5,
	parameter BOD_DLY = 14
) (
	// Peripheral clock
	input  wire clock,
	// Source enable from the controller
	input  wire mclk_src_en,
	// Readiness back
	output reg  osc_ready = 1'b0,
	output reg  bod_ready = 1'b0
);
	integer cnt = 0;
	always @(posedge clock) begin
		cnt <= mclk_src_en ? cnt + 1 : 0;
		osc_ready <= mclk_src_en && cnt >= OSC_DLY;
		bod_ready <= mclk_src_en && cnt >= BOD_DLY;
	end
endmodule // slc_partner

// ### test/tb_sleep_mode_controller.sv
`timescale 1ns/100ps
`include "slc_map.vh"
module tb_sleep_mode_controller;
	reg        clock = 1'b0;
	reg        rst_n = 1'b0;
	reg  [7:0] reg_addr = 8'h00;
	reg  [7:0] reg_wdata = 8'h00;
	reg        reg_write = 1'b0;
	reg        reg_read = 1'b0;
	reg        sleep_instr = 1'b0;
	// Wake sources: pin, twi, tcb, other, usart, adc window, debug
	reg  [6:0] src = 7'h00;
	reg  [5:0] rsb = 6'h2a;
	wire [7:0] reg_rdata;
	wire       cpu_clk_en, wake_irq, sleeping, mclk_src_en, osc_ready, bod_ready;
	wire       per_clk_en, adc_clk_en, rtc_en, rtcclk_src_en, ulp32k_en, pit_en, watchdog_en;
	wire       mem_retain;
	// Domain enables, per, adc, rtc, mclk, rtcclk, ulp, pit, watchdog from the top
	wire [7:0] dom = {per_clk_en, adc_clk_en, rtc_en, mclk_src_en, rtcclk_src_en, ulp32k_en,
		pit_en, watchdog_en};
	integer    num_errors = 0;
	integer    tests_run = 0;
	integer    m;
	always #4 clock = ~clock;
	slc_sleep_controller i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .sleep_instr(sleep_instr), .cpu_clk_en(cpu_clk_en),
		.wake_irq(wake_irq), .pin_irq(src[0]), .twi_addr_match(src[1]), .pit_irq(1'b0),
		.rtc_irq(1'b0), .debug_break(src[6]), .tcb_irq(src[2]), .usart_sof_irq(src[4]),
		.adc_window_irq(src[5]), .other_irq(src[3]), .per_run_in_standby_bit(rsb[0]),
		.rtc_run_in_standby_bit(rsb[1]), .adc_run_in_standby_bit(rsb[2]),
		.usart_run_in_standby_bit(rsb[3]), .mclk_run_in_standby_bit(rsb[4]),
		.rtcclk_run_in_standby_bit(rsb[5]), .osc_ready(osc_ready), .bod_ready(bod_ready),
		.brownout_config_fuse(2'h3), .bod_uses_ulp(rsb[5]), .watchdog_uses_ulp(rsb[1]),
		.per_clk_en(per_clk_en), .adc_clk_en(adc_clk_en), .rtc_en(rtc_en),
		.mclk_src_en(mclk_src_en), .rtcclk_src_en(rtcclk_src_en), .ulp32k_en(ulp32k_en),
		.pit_en(pit_en), .watchdog_en(watchdog_en), .sleeping(sleeping),
		.mem_retain(mem_retain));
	slc_partner i_osc (.clock(clock), .mclk_src_en(mclk_src_en), .osc_ready(osc_ready),
		.bod_ready(bod_ready));
	task test_done;
		begin
			$display("checks %0d errors %0d", tests_run, num_errors);
			if (num_errors == 0 && tests_run > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_wdata <= d;
			reg_write <= 1'b1;
			@(posedge clock);
			reg_write <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		begin
			@(posedge clock);
			reg_addr <= a;
			reg_read <= 1'b1;
			@(posedge clock);
			reg_read <= 1'b0;
			#1 chk(reg_rdata, exp);
		end
	endtask
	task slp(input [7:0] c, input s);
		begin
			wr(`SLC_CTRL_OFS, c);
			@(posedge clock);
			sleep_instr <= 1'b1;
			@(posedge clock);
			sleep_instr <= 1'b0;
			#1 chk({7'h00, sleeping}, {7'h00, s});
		end
	endtask
	task wk(input [6:0] w, input e);
		integer i;
		begin
			@(posedge clock);
			src <= w;
			for (i = 0; i < 200 && cpu_clk_en !== 1'b1; i = i + 1) begin
				@(posedge clock);
				#1;
			end
			if (i == 200) begin
				chk(8'h00, 8'h01);
				test_done;
			end
			chk({7'h00, wake_irq}, {7'h00, e});
			@(posedge clock);
			src <= 7'h00;
		end
	endtask
	initial begin
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		rd(`SLC_CTRL_OFS, `SLC_CTRL_RST);
		wr(`SLC_CTRL_OFS, 8'hff);
		rd(`SLC_CTRL_OFS, 8'h07);
		wr(`SLC_STAT_OFS, 8'hff);
		rd(`SLC_STAT_OFS, 8'h00);
		rd(8'h05, 8'h00);
		slp(8'h06, 1'b0);
		slp(8'h07, 1'b0);
		$display("test registers end");
		for (m = 0; m < 3; m = m + 1) begin
			slp({5'h00, m[1:0], 1'b1}, 1'b1);
			// Standby run-in-standby pattern keeps rtc and rtc clock, drops per, adc, mclk
			chk(dom, m == 0 ? 8'hff : (m == 1 ? 8'h2f : 8'h0f));
			chk({7'h00, mem_retain}, 8'h01);
			rd(`SLC_STAT_OFS, m[7:0] + 8'h01);
			if (m > 0) begin
				@(posedge clock);
				// Other irq and an adc window whose run-in-standby bit is clear
				src <= 7'h28;
				repeat (20) @(posedge clock);
				#1 chk({7'h00, sleeping}, 8'h01);
			end
			wk(m == 0 ? 7'h08 : (m == 1 ? 7'h10 : 7'h01), 1'b1);
			rd(`SLC_STAT_OFS, 8'h00);
		end
		$display("test modes end");
		slp(8'h05, 1'b1);
		wk(7'h40, 1'b0);
		rd(`SLC_STAT_OFS, 8'h08);
		slp(8'h03, 1'b1);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (4) @(posedge clock);
		chk({6'h00, sleeping, cpu_clk_en}, 8'h01);
		rst_n <= 1'b1;
		rd(`SLC_CTRL_OFS, 8'h00);
		$display("test debug and reset end");
		test_done;
	end
endmodule // tb_sleep_mode_controller
